// ---- include/mas_pkg.sv ----
// What this block does
// - de-energising alarm cuts current, applies brake
// - energising alarm keeps winding current flowing
// - homing ended abnormally raises code 62h
// - no origin sensor between limits, 63h
// - no timing/zero/sensor_input_a edge in homing, 64h
// - hardware overtravel raises 66h, seven blinks
// - commanded position hits soft limit, 67h
// - limit sensor during homing offset, 6ah
// - bad motion data chain or speed, 70h
// - bad gear resolution, 71h, power cycle
// - network disconnect while running raises 81h
// - bad rate switch, 83h, de-energise, latched
// - error count reaches threshold, 84h, blinks
// - communication timeout expired raises 85h
// - converter reports its own alarm, 8eh
package mas_pkg;
    // alarm codes
    localparam logic [7:0] MAS_C_HOME_FAIL = 8'h62;
    localparam logic [7:0] MAS_C_NO_ORIGIN = 8'h63;
    localparam logic [7:0] MAS_C_NO_EDGE = 8'h64;
    localparam logic [7:0] MAS_C_HW_OT = 8'h66;
    localparam logic [7:0] MAS_C_SW_OT = 8'h67;
    localparam logic [7:0] MAS_C_OFS_LIM = 8'h6a;
    localparam logic [7:0] MAS_C_BAD_DATA = 8'h70;
    localparam logic [7:0] MAS_C_GEAR = 8'h71;
    localparam logic [7:0] MAS_C_NET_BUS = 8'h81;
    localparam logic [7:0] MAS_C_BAUD = 8'h83;
    localparam logic [7:0] MAS_C_COMM_ERR = 8'h84;
    localparam logic [7:0] MAS_C_COMM_TO = 8'h85;
    localparam logic [7:0] MAS_C_CONV = 8'h8e;
    // event bit numbers, one per alarm source
    localparam int MAS_NEV = 13;
    localparam int MAS_E_HOME_FAIL = 0;
    localparam int MAS_E_NO_ORIGIN = 1;
    localparam int MAS_E_NO_EDGE = 2;
    localparam int MAS_E_HW_OT = 3;
    localparam int MAS_E_SW_OT = 4;
    localparam int MAS_E_OFS_LIM = 5;
    localparam int MAS_E_BAD_DATA = 6;
    localparam int MAS_E_GEAR = 7;
    localparam int MAS_E_NET_BUS = 8;
    localparam int MAS_E_BAUD = 9;
    localparam int MAS_E_COMM_ERR = 10;
    localparam int MAS_E_COMM_TO = 11;
    localparam int MAS_E_CONV = 12;
    // code per event bit, index order as above
    localparam logic [MAS_NEV*8-1:0] MAS_CODE_TAB = {MAS_C_CONV, MAS_C_COMM_TO, MAS_C_COMM_ERR,
        MAS_C_BAUD, MAS_C_NET_BUS, MAS_C_GEAR, MAS_C_BAD_DATA, MAS_C_OFS_LIM, MAS_C_SW_OT,
        MAS_C_HW_OT, MAS_C_NO_EDGE, MAS_C_NO_ORIGIN, MAS_C_HOME_FAIL};
    // resettable alarms; gear and rate switch need a power cycle
    localparam logic [MAS_NEV-1:0] MAS_RESETTABLE = 13'h1d7f;
    // alarms that keep excitation on; gear and rate switch cut it
    localparam logic [MAS_NEV-1:0] MAS_KEEP_EXC = 13'h1d7f;
    // blink counts: seven for hardware overtravel and comm errors, else one
    localparam logic [3:0] MAS_BLINK_SEVEN = 4'h7;
    localparam logic [3:0] MAS_BLINK_ONE = 4'h1;
    // register byte offsets
    localparam logic [7:0] MAS_R_STATUS = 8'h00;
    localparam logic [7:0] MAS_R_ENABLE = 8'h04;
    localparam logic [7:0] MAS_R_CLEAR = 8'h08;
    localparam logic [7:0] MAS_R_CODE = 8'h0c;
    localparam logic [7:0] MAS_R_CFG = 8'h10;
    localparam logic [7:0] MAS_R_SOFTLIM = 8'h14;
    localparam logic [7:0] MAS_R_ERRTH = 8'h18;
    localparam logic [7:0] MAS_R_TIMEOUT = 8'h1c;
    // config bits
    localparam int MAS_CFG_HW_OT = 0;
    localparam int MAS_CFG_SW_OT = 1;
    localparam logic [1:0] MAS_RESP_OK = 2'b00;
    localparam logic [1:0] MAS_RESP_ERR = 2'b10;
    // lamp timing: 250 ms half period at 20 MHz
    localparam int MAS_CLK_HZ = 20000000;
    localparam int MAS_BLINK_MS = 250;
    localparam int MAS_BLINK_CYC = MAS_CLK_HZ / 1000 * MAS_BLINK_MS;
    localparam logic [7:0] MAS_ERRTH_RST = 8'h03;
    localparam logic [31:0] MAS_TIMEOUT_RST = 32'h00000000;
endpackage

// ---- core/mas_supervisor.sv ----
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mas_supervisor
    import mas_pkg::*;
#(
    parameter int BLINK_CYC = MAS_BLINK_CYC,
    parameter int POS_W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // motion controller events
    input wire logic homing_active,
    input wire logic homing_done_bad,
    input wire logic homing_three_sensor,
    input wire logic homing_origin_pass,
    input wire logic homing_offset_move,
    input wire logic homing_edge_miss,
    input wire logic origin_sensor_input,
    input wire logic forward_limit_sensor,
    input wire logic reverse_limit_sensor,
    input wire logic step_phase_timing_output,
    input wire logic encoder_zero_output,
    input wire logic sensor_input_a,
    input wire logic signed [POS_W-1:0] command_position,
    input wire logic motor_running,
    input wire logic data_bad,
    input wire logic gear_bad,
    input wire logic baud_bad,
    input wire logic comm_error,
    input wire logic comm_ok,
    input wire logic master_disconnected,
    input wire logic converter_alarm,
    input wire logic fault_clear_input,
    // outputs
    output logic motor_current_en,
    output logic brake_engage,
    output logic alarm_lamp,
    output logic alarm_active,
    output logic [7:0] alarm_code,
    output logic irq
);
    // register state
    logic [MAS_NEV-1:0] status_ff, nxt_status; // sticky alarm bits
    logic [MAS_NEV-1:0] irq_en_ff; // interrupt enables
    logic [1:0] cfg_ff; // overtravel enables
    logic signed [POS_W-1:0] softlim_ff; // soft limit value
    logic [7:0] errth_ff; // comm error threshold
    logic [31:0] tmo_ff; // timeout cycles, zero disables
    logic [7:0] code_ff; // latest alarm code
    logic [7:0] errcnt_ff; // consecutive comm errors
    logic [31:0] tmocnt_ff; // cycles without contact
    logic linked_ff; // contact ever made
    logic fclr_ff; // clear input delayed for edge
    // bus state
    logic aw_ff, w_ff; // captured halves
    logic [7:0] awa_ff; // held write address
    logic [31:0] wd_ff; // held write data
    logic bv_ff; // write answer pending
    logic arr_ff; // read slot free
    logic rv_ff; // read answer pending
    logic [31:0] rd_ff; // read data held
    logic [1:0] rr_ff; // read response held
    // lamp state
    logic [31:0] bt_ff; // cycles into lamp phase
    logic [3:0] bn_ff; // blinks in this burst
    logic lamp_ff; // lamp drive
    logic gap_ff; // first dark period of gap

    // event detection
    logic [MAS_NEV-1:0] ev;
    wire any_ls = forward_limit_sensor | reverse_limit_sensor;
    wire edge_seen = step_phase_timing_output | encoder_zero_output | sensor_input_a;
    assign ev[MAS_E_HOME_FAIL] = homing_done_bad;
    // sensor faults count only inside homing
    assign ev[MAS_E_NO_ORIGIN] = homing_active & homing_three_sensor & any_ls & ~homing_origin_pass
        & ~origin_sensor_input;
    assign ev[MAS_E_NO_EDGE] = homing_active & homing_edge_miss & ~edge_seen;
    // homing alarms own the limits while homing
    assign ev[MAS_E_HW_OT] = cfg_ff[MAS_CFG_HW_OT] & any_ls & ~homing_active;
    assign ev[MAS_E_SW_OT] = cfg_ff[MAS_CFG_SW_OT] & (command_position >= softlim_ff);
    assign ev[MAS_E_OFS_LIM] = homing_offset_move & any_ls;
    assign ev[MAS_E_BAD_DATA] = data_bad;
    assign ev[MAS_E_GEAR] = gear_bad;
    assign ev[MAS_E_NET_BUS] = master_disconnected & motor_running;
    assign ev[MAS_E_BAUD] = baud_bad;
    assign ev[MAS_E_COMM_ERR] = (errcnt_ff >= errth_ff) & (errth_ff != 8'h00);
    assign ev[MAS_E_COMM_TO] = (tmo_ff != 32'h0) & ~linked_ff & (tmocnt_ff >= tmo_ff);
    assign ev[MAS_E_CONV] = converter_alarm;

    // bus decode
    // a write acts once, both halves held
    wire wr_go = aw_ff & w_ff & ~bv_ff;
    // unmapped or unaligned: error response
    wire wr_map = (awa_ff <= MAS_R_TIMEOUT) & (awa_ff[1:0] == 2'b00);
    wire wr_en = wr_go & (awa_ff == MAS_R_ENABLE);
    wire wr_clr = wr_go & (awa_ff == MAS_R_CLEAR);
    wire wr_cfg = wr_go & (awa_ff == MAS_R_CFG);
    wire wr_lim = wr_go & (awa_ff == MAS_R_SOFTLIM);
    wire wr_th = wr_go & (awa_ff == MAS_R_ERRTH);
    wire wr_to = wr_go & (awa_ff == MAS_R_TIMEOUT);
    // a read is taken while the slot is free
    wire rd_go = s_axi_arvalid & arr_ff;
    wire rd_map = (s_axi_araddr <= MAS_R_TIMEOUT) & (s_axi_araddr[1:0] == 2'b00);
    logic [31:0] rd_mux;
    always_comb begin
        // read data select
        case (s_axi_araddr)
            MAS_R_STATUS: rd_mux = {{(32-MAS_NEV){1'b0}}, status_ff};
            MAS_R_ENABLE: rd_mux = {{(32-MAS_NEV){1'b0}}, irq_en_ff};
            MAS_R_CODE: rd_mux = {24'h0, code_ff};
            MAS_R_CFG: rd_mux = {30'h0, cfg_ff};
            MAS_R_SOFTLIM: rd_mux = 32'(softlim_ff);
            MAS_R_ERRTH: rd_mux = {24'h0, errth_ff};
            MAS_R_TIMEOUT: rd_mux = tmo_ff;
            default: rd_mux = 32'h0; // clear reads zero
        endcase
    end

    // clearing: software clear bits, or the clear input edge on resettable bits
    // a held clear input acts once
    wire fclr_edge = fault_clear_input & ~fclr_ff;
    wire [MAS_NEV-1:0] clr_mask = (wr_clr ? wd_ff[MAS_NEV-1:0] : '0)
        | (fclr_edge ? MAS_RESETTABLE : '0);
    // set wins over clear; non-resettable bits only clear at reset
    assign nxt_status = (status_ff & ~(clr_mask & MAS_RESETTABLE)) | ev;

    // newest alarm code: lowest new event wins a tie
    // scanning downward, the lowest bit writes last
    logic [7:0] new_code;
    logic new_any;
    always_comb begin
        new_code = code_ff;
        new_any = 1'b0;
        for (int i = MAS_NEV-1; i >= 0; i--) begin
            if (ev[i] & ~status_ff[i]) begin
                new_code = MAS_CODE_TAB[i*8 +: 8];
                new_any = 1'b1;
            end
        end
    end
    // any alarm outside the keep mask cuts current
    wire keep_exc = ((nxt_status & ~MAS_KEEP_EXC) == '0);
    wire any_alarm = |nxt_status;
    // hardware overtravel or comm errors blink seven
    wire seven = nxt_status[MAS_E_HW_OT] | nxt_status[MAS_E_COMM_ERR];
    wire [3:0] blink_n = seven ? MAS_BLINK_SEVEN : MAS_BLINK_ONE;

    // status, code and excitation
    // outputs move with the status bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= '0;
            code_ff <= 8'h0;
            motor_current_en <= 1'b1;
            brake_engage <= 1'b0;
            alarm_active <= 1'b0;
            irq <= 1'b0;
            fclr_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            fclr_ff <= fault_clear_input;
            code_ff <= new_any ? new_code : (any_alarm ? code_ff : 8'h0);
            motor_current_en <= keep_exc;
            brake_engage <= ~keep_exc;
            alarm_active <= any_alarm;
            irq <= |(nxt_status & irq_en_ff);
        end
    end
    assign alarm_code = code_ff;

    // communication counters
    // a good frame restarts the error count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            errcnt_ff <= 8'h0;
            tmocnt_ff <= 32'h0;
            linked_ff <= 1'b0;
        end else begin
            if (comm_ok) begin
                errcnt_ff <= 8'h0; // consecutive count restarts
            end else if (comm_error && errcnt_ff != 8'hff) begin
                errcnt_ff <= errcnt_ff + 8'h1;
            end
            if (comm_ok) begin
                linked_ff <= 1'b1;
            end
            if (!linked_ff && tmocnt_ff != 32'hffffffff) begin
                tmocnt_ff <= tmocnt_ff + 32'h1;
            end
        end
    end

    // lamp: n blinks, then a gap of two blink periods, repeating
    // a clean status returns the lamp to dark
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bt_ff <= 32'h0;
            bn_ff <= 4'h0;
            lamp_ff <= 1'b0;
            gap_ff <= 1'b0;
        end else if (!any_alarm) begin
            bt_ff <= 32'h0;
            bn_ff <= 4'h0;
            lamp_ff <= 1'b0;
            gap_ff <= 1'b0;
        end else if (bt_ff < 32'(BLINK_CYC - 1)) begin
            bt_ff <= bt_ff + 32'h1;
        end else begin
            bt_ff <= 32'h0;
            if (gap_ff) begin
                // first dark period of gap ends; lamp lights after the next one
                gap_ff <= 1'b0;
            end else if (lamp_ff) begin
                lamp_ff <= 1'b0;
                bn_ff <= bn_ff + 4'h1;
                if (bn_ff + 4'h1 >= blink_n) begin
                    bn_ff <= 4'h0;
                    gap_ff <= 1'b1;
                end
            end else begin
                lamp_ff <= 1'b1;
            end
        end
    end
    assign alarm_lamp = lamp_ff;

    // axi write channel
    // each half is held until the answer is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awa_ff <= 8'h0;
            wd_ff <= 32'h0;
            bv_ff <= 1'b0;
            s_axi_bresp <= MAS_RESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_ff) begin
                aw_ff <= 1'b1;
                awa_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ff) begin
                w_ff <= 1'b1;
                wd_ff <= s_axi_wdata;
            end
            if (wr_go) begin
                bv_ff <= 1'b1;
                s_axi_bresp <= wr_map ? MAS_RESP_OK : MAS_RESP_ERR;
            end
            // taken answer frees both halves
            if (bv_ff && s_axi_bready) begin
                bv_ff <= 1'b0;
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
            end
        end
    end
    assign s_axi_awready = ~aw_ff;
    assign s_axi_wready = ~w_ff;
    assign s_axi_bvalid = bv_ff;

    // writable registers
    // only each field is kept, upper bits drop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_ff <= '0;
            cfg_ff <= 2'b00;
            softlim_ff <= '0;
            errth_ff <= MAS_ERRTH_RST;
            tmo_ff <= MAS_TIMEOUT_RST;
        end else begin
            if (wr_en) begin
                irq_en_ff <= wd_ff[MAS_NEV-1:0];
            end
            if (wr_cfg) begin
                cfg_ff <= wd_ff[1:0];
            end
            if (wr_lim) begin
                softlim_ff <= POS_W'(wd_ff);
            end
            if (wr_th) begin
                errth_ff <= wd_ff[7:0];
            end
            if (wr_to) begin
                tmo_ff <= wd_ff;
            end
        end
    end

    // axi read channel
    // data stands with the answer until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arr_ff <= 1'b1;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0;
            rr_ff <= MAS_RESP_OK;
        end else begin
            if (rd_go) begin
                arr_ff <= 1'b0;
                rv_ff <= 1'b1;
                rd_ff <= rd_mux;
                rr_ff <= rd_map ? MAS_RESP_OK : MAS_RESP_ERR;
            end else if (rv_ff && s_axi_rready) begin
                rv_ff <= 1'b0;
                arr_ff <= 1'b1;
            end
        end
    end
    assign s_axi_arready = arr_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rd_ff;
    assign s_axi_rresp = rr_ff;

    // assertions
    gear_nonclear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        status_ff[MAS_E_GEAR] |=> status_ff[MAS_E_GEAR])
        else $error("gear alarm cleared without reset");
    baud_deexc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        status_ff[MAS_E_BAUD] |=> !motor_current_en)
        else $error("rate switch alarm kept excitation");
    keep_exc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (status_ff[MAS_E_NET_BUS] && !status_ff[MAS_E_GEAR] && !status_ff[MAS_E_BAUD]
        && !ev[MAS_E_GEAR] && !ev[MAS_E_BAUD]) |=> motor_current_en)
        else $error("resettable alarm cut excitation");
    brake_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !motor_current_en |-> brake_engage)
        else $error("brake free while current off");
    home_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        homing_done_bad |=> status_ff[MAS_E_HOME_FAIL])
        else $error("homing failure not latched");
    ofs_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (homing_offset_move && forward_limit_sensor) |=> status_ff[MAS_E_OFS_LIM])
        else $error("offset limit alarm missed");
    conv_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (converter_alarm && !status_ff[MAS_E_CONV] && ev[MAS_NEV-2:0] == '0) |=> alarm_code == MAS_C_CONV)
        else $error("converter code not shown");
    clr_input_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fclr_edge && ev == '0) |=> (status_ff & MAS_RESETTABLE) == '0)
        else $error("clear input left resettable alarm");
    swot_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_ff[MAS_CFG_SW_OT] && command_position >= softlim_ff) |=> status_ff[MAS_E_SW_OT])
        else $error("soft limit alarm missed");
    net_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (master_disconnected && motor_running) |=> status_ff[MAS_E_NET_BUS])
        else $error("disconnect alarm missed");
    gear_deexc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        status_ff[MAS_E_GEAR] |=> brake_engage)
        else $error("gear alarm kept excitation");
    lamp_dark_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !alarm_active |-> !alarm_lamp)
        else $error("lamp lit with no alarm");
endmodule // mas_supervisor
`default_nettype wire

// ---- bench/mas_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host master controller and network converter as seen by the supervisor
module mas_host_model (
    input wire logic aclk,
    input wire logic link_down_req,
    input wire logic conv_fault_req,
    output logic comm_error,
    output logic comm_ok,
    output logic master_disconnected,
    output logic converter_alarm
);
    // converter status lines follow the requests of the bench
    assign master_disconnected = link_down_req;
    assign converter_alarm = conv_fault_req;

    // quiet link at time zero
    initial begin
        comm_error = 1'b0;
        comm_ok = 1'b0;
    end

    // one frame: a one-cycle pulse, good or bad, after an idle gap
    task automatic frame(input logic good, input int gap);
        repeat (gap) @(posedge aclk);
        @(posedge aclk);
        comm_error <= !good;
        comm_ok <= good;
        @(posedge aclk);
        comm_error <= 1'b0;
        comm_ok <= 1'b0;
    endtask
endmodule // mas_host_model
`default_nettype wire

// ---- bench/test_motion_alarm_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_motion_alarm_supervisor;
    import mas_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [12:0] ev; // one drive bit per alarm source; the comm error and timeout bits drive nothing
    logic fault_clear_input, comm_error, comm_ok, master_disconnected, converter_alarm;
    logic motor_current_en, brake_engage, alarm_lamp, alarm_active, irq;
    logic [7:0] alarm_code;
    logic signed [31:0] command_position;
    logic [1:0] aux; // origin sensor, timing output
    int num_errors = 0;
    int n_tests = 0;
    int nb;
    // expected code per status bit
    logic [7:0] codes [13] = '{MAS_C_HOME_FAIL, MAS_C_NO_ORIGIN, MAS_C_NO_EDGE, MAS_C_HW_OT, MAS_C_SW_OT,
        MAS_C_OFS_LIM, MAS_C_BAD_DATA, MAS_C_GEAR, MAS_C_NET_BUS, MAS_C_BAUD, MAS_C_COMM_ERR, MAS_C_COMM_TO, MAS_C_CONV};
    int rlist [9] = '{0, 1, 2, 3, 4, 5, 6, 8, 12};

    // soft limit is programmed to 100, so 100 sits exactly on it
    assign command_position = ev[4] ? 32'sd100 : 32'sd0;

    mas_supervisor #(.BLINK_CYC(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .homing_active(ev[1] | ev[2] | ev[5]), .homing_done_bad(ev[0]), .homing_three_sensor(ev[1]),
        .homing_origin_pass(1'b0), .homing_offset_move(ev[5]), .homing_edge_miss(ev[2]),
        .origin_sensor_input(aux[1]), .forward_limit_sensor(ev[1] | ev[3]), .reverse_limit_sensor(ev[5]),
        .step_phase_timing_output(aux[0]), .encoder_zero_output(1'b0), .sensor_input_a(1'b0),
        .command_position(command_position), .motor_running(ev[8]), .data_bad(ev[6]), .gear_bad(ev[7]),
        .baud_bad(ev[9]), .comm_error(comm_error), .comm_ok(comm_ok),
        .master_disconnected(master_disconnected), .converter_alarm(converter_alarm),
        .fault_clear_input(fault_clear_input), .motor_current_en(motor_current_en),
        .brake_engage(brake_engage), .alarm_lamp(alarm_lamp), .alarm_active(alarm_active),
        .alarm_code(alarm_code), .irq(irq)
    );

    mas_host_model u_host (
        .aclk(aclk), .link_down_req(ev[8]), .conv_fault_req(ev[12]), .comm_error(comm_error),
        .comm_ok(comm_ok), .master_disconnected(master_disconnected), .converter_alarm(converter_alarm)
    );

    // free-running bench clock, 50 ns period
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // verdict and end of run
    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // axi4-lite write, both halves offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    // axi4-lite read
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // read a register and compare data and response
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        axr(a, rd, rs);
        chk("rdata", exp, rd);
        chk("rresp", {30'h0, er}, {30'h0, rs});
    endtask

    // hold one alarm cause for two cycles, then let it settle
    task automatic fire(input int k);
        @(posedge aclk);
        ev[k] <= 1'b1;
        repeat (2) @(posedge aclk);
        ev[k] <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // rising edge on the clear input
    task automatic pin_clear();
        @(posedge aclk);
        fault_clear_input <= 1'b1;
        repeat (2) @(posedge aclk);
        fault_clear_input <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // reset held for sixteen cycles
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // count lamp blinks over one burst window
    task automatic blinks(output int n);
        logic prev;
        n = 0;
        prev = alarm_lamp;
        repeat (60) begin
            @(posedge aclk);
            if (alarm_lamp === 1'b0 && prev === 1'b1) n++;
            prev = alarm_lamp;
        end
    endtask

    // alarm code, current enable and brake against expected values
    task automatic outs(input logic [7:0] c, input logic cur);
        chk("alarm_code", {24'h0, c}, {24'h0, alarm_code});
        chk("motor_current_en", {31'h0, cur}, {31'h0, motor_current_en});
        chk("brake_engage", {31'h0, !cur}, {31'h0, brake_engage});
    endtask

    // bound on a hung run
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        final_report();
    end

    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fault_clear_input} = '0;
        {awaddr, araddr, wdata, ev, aux} = '0;
        do_reset();
        rchk(MAS_R_STATUS, 32'h0, MAS_RESP_OK);
        rchk(MAS_R_ERRTH, {24'h0, MAS_ERRTH_RST}, MAS_RESP_OK);
        rchk(8'h40, 32'h0, MAS_RESP_ERR);
        axw(8'h40, 32'h1, rs);
        chk("bresp", {30'h0, MAS_RESP_ERR}, {30'h0, rs});
        outs(8'h00, 1'b1);
        axw(MAS_R_ENABLE, 32'h1fff, rs);
        axw(MAS_R_SOFTLIM, 32'd100, rs);
        axw(MAS_R_CFG, 32'h3, rs);
        // origin and timing seen: no homing alarm
        @(posedge aclk);
        aux <= 2'b11;
        fire(1);
        fire(2);
        rchk(MAS_R_STATUS, 32'h0, MAS_RESP_OK);
        aux <= 2'b00;
        // every resettable source but comm error and timeout: raise, check, clear by pin or register
        foreach (rlist[i]) begin
            fire(rlist[i]);
            rchk(MAS_R_STATUS, 32'h1 << rlist[i], MAS_RESP_OK);
            outs(codes[rlist[i]], 1'b1);
            chk("irq", 32'h1, {31'h0, irq});
            if (rlist[i] == 3) begin
                blinks(nb);
                chk("blinks", 32'd7, nb);
            end
            if (i % 2 == 0) pin_clear();
            else axw(MAS_R_CLEAR, 32'h1 << rlist[i], rs);
            rchk(MAS_R_STATUS, 32'h0, MAS_RESP_OK);
            outs(8'h00, 1'b1);
            chk("irq", 32'h0, {31'h0, irq});
        end
        // newest alarm code wins while both stay latched
        fire(6);
        fire(12);
        rchk(MAS_R_STATUS, 32'h1040, MAS_RESP_OK);
        outs(MAS_C_CONV, 1'b1);
        pin_clear();
        // consecutive communication errors against threshold 3
        u_host.frame(1'b0, 0);
        u_host.frame(1'b0, 3);
        u_host.frame(1'b1, 0);
        u_host.frame(1'b0, 0);
        u_host.frame(1'b0, 0);
        rchk(MAS_R_STATUS, 32'h0, MAS_RESP_OK);
        u_host.frame(1'b0, 0);
        repeat (2) @(posedge aclk);
        outs(MAS_C_COMM_ERR, 1'b1);
        blinks(nb);
        chk("blinks", 32'd7, nb);
        pin_clear();
        // communication timeout of twenty cycles from a fresh reset
        do_reset();
        axw(MAS_R_TIMEOUT, 32'd20, rs);
        rchk(MAS_R_STATUS, 32'h0, MAS_RESP_OK);
        repeat (40) @(posedge aclk);
        rchk(MAS_R_STATUS, 32'h1 << MAS_E_COMM_TO, MAS_RESP_OK);
        axw(MAS_R_TIMEOUT, 32'd0, rs);
        pin_clear();
        rchk(MAS_R_STATUS, 32'h0, MAS_RESP_OK);
        // latched alarms that cut excitation and ignore every clear
        fire(7);
        outs(MAS_C_GEAR, 1'b0);
        fire(9);
        outs(MAS_C_BAUD, 1'b0);
        pin_clear();
        axw(MAS_R_CLEAR, 32'h1fff, rs);
        rchk(MAS_R_STATUS, 32'h0280, MAS_RESP_OK);
        chk("motor_current_en", 32'h0, {31'h0, motor_current_en});
        axw(MAS_R_ENABLE, 32'h0, rs);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        axw(MAS_R_ENABLE, 32'h80, rs);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        do_reset();
        rchk(MAS_R_STATUS, 32'h0, MAS_RESP_OK);
        outs(8'h00, 1'b1);
        final_report();
    end
endmodule // test_motion_alarm_supervisor
`default_nettype wire
